// >>> src/tci_consts.vh
// register offsets, field positions and reset values for the timer control block
`ifndef TCI_CONSTS_VH
`define TCI_CONSTS_VH

`define TCI_ADDR_W        8
`define TCI_OFF_CTL       8'h0C
`define TCI_OFF_MASK      8'h18
`define TCI_OFF_RAW       8'h1C
`define TCI_OFF_MIS       8'h20
`define TCI_OFF_CLR       8'h24

`define TCI_CTL_A_EN      0
`define TCI_CTL_A_FREEZE  1
`define TCI_CTL_A_EDGE_LO 2
`define TCI_CTL_A_EDGE_HI 3
`define TCI_CTL_CAL_EN    4
`define TCI_CTL_A_TRIG    5
`define TCI_CTL_A_INV     6
`define TCI_CTL_B_EN      8
`define TCI_CTL_WMASK     32'h0000017F
`define TCI_CTL_RESET     32'h00000000

`define TCI_IRQ_WMASK     32'h0000070F
`define TCI_IRQ_RESET     32'h00000000
`define TCI_IRQ_N         11

`define TCI_EDGE_RISE     2'h0
`define TCI_EDGE_FALL     2'h1
`define TCI_EDGE_BOTH     2'h3

`define TCI_RESP_OKAY     2'h0
`define TCI_RESP_SLVERR   2'h2

`endif

// >>> src/tci_edge_detect.v
// capture edge detector for the half a input
`timescale 1ns/1ns
`include "tci_consts.vh"

module tci_edge_detect (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       enable,
    input  wire [1:0] edge_select,
    input  wire       sample_in,
    output reg        event_pulse
);
    reg sample_r;

    // previous sample and pulse; enable gates the capture logic
    always @(posedge aclk) begin
        if (!aresetn) begin
            sample_r    <= 1'b0;
            event_pulse <= 1'b0;
        end else begin
            sample_r <= sample_in;
            case (edge_select)
                `TCI_EDGE_RISE: event_pulse <= enable & sample_in & ~sample_r;
                `TCI_EDGE_FALL: event_pulse <= enable & ~sample_in & sample_r;
                `TCI_EDGE_BOTH: event_pulse <= enable & (sample_in ^ sample_r);
                default:        event_pulse <= 1'b0; // reserved code never fires
            endcase
        end
    end
endmodule // tci_edge_detect

// >>> src/tci_status_bits.v
// sticky event flags with write-one-to-clear, one per source
`timescale 1ns/1ns

module tci_status_bits #(
    parameter N = 11
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [N-1:0] event_in,
    input  wire [N-1:0] clear_in,
    output wire [N-1:0] status
);
    reg [N-1:0] flag_r;
    genvar i;

    // set has priority so an event in the clearing cycle is kept
    generate
        for (i = 0; i < N; i = i + 1) begin : g_flag
            always @(posedge aclk) begin
                if (!aresetn)
                    flag_r[i] <= 1'b0;
                else if (event_in[i])
                    flag_r[i] <= 1'b1;
                else if (clear_in[i])
                    flag_r[i] <= 1'b0;
            end
        end
    endgenerate

    assign status = flag_r;
endmodule // tci_status_bits

// >>> src/tci_top.v
// timer control and interrupt registers with AXI4-Lite slave
`timescale 1ns/1ns
`include "tci_consts.vh"

module tci_top #(
    parameter ADDR_W = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              a_timeout_evt,
    input  wire              a_match_evt,
    input  wire              a_capture_in,
    input  wire              calendar_evt,
    input  wire              b_timeout_evt,
    input  wire              b_match_evt,
    input  wire              b_capture_evt,
    input  wire              a_wave_in,
    input  wire              a_trigger_in,
    input  wire              stall_req,
    output reg               half_a_run,
    output reg               half_b_run,
    output reg               half_a_wave_out,
    output reg               half_a_trigger_out,
    output reg               calendar_count_run,
    output reg               half_a_freeze,
    output wire [1:0]        half_a_edge_select,
    output reg               irq
);
    reg  [31:0]        ctl_r;
    reg  [31:0]        mask_r;
    reg  [ADDR_W-1:0]  awaddr_r;
    reg                aw_have_r;
    reg  [31:0]        wdata_r;
    reg  [3:0]         wstrb_r;
    reg                w_have_r;
    wire [`TCI_IRQ_N-1:0] raw;
    wire [`TCI_IRQ_N-1:0] events;
    reg  [`TCI_IRQ_N-1:0] clear_strobe;
    wire [31:0]        raw_word;
    wire [31:0]        mis_word;
    wire               a_capture_evt;
    wire               do_write;
    wire [31:0]        wbytes;
    wire [31:0]        ctl_nxt;
    wire [31:0]        mask_nxt;

    // channels accept once each until their response is taken
    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_have_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write      = aw_have_r & w_have_r & ~s_axi_bvalid;

    // byte lane expansion of the write strobes
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
            assign wbytes[lane*8 +: 8] = {8{wstrb_r[lane]}};
        end
    endgenerate

    // reserved bits are never stored, whatever software writes
    assign ctl_nxt  = (ctl_r & ~(wbytes & `TCI_CTL_WMASK))
                    | (wdata_r & wbytes & `TCI_CTL_WMASK);
    assign mask_nxt = (mask_r & ~(wbytes & `TCI_IRQ_WMASK))
                    | (wdata_r & wbytes & `TCI_IRQ_WMASK);

    // write address and data latches, in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            awaddr_r  <= {ADDR_W{1'b0}};
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_have_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // write address decode, one hit per mapped word
    wire [7:0]  wr_index;
    wire        wr_hit_ctl;
    wire        wr_hit_mask;
    wire        wr_hit_raw;
    wire        wr_hit_mis;
    wire        wr_hit_clr;
    wire        wr_hit_any;
    wire [31:0] clr_bits;

    assign wr_index    = {2'b00, awaddr_r[7:2]};
    assign wr_hit_ctl  = (wr_index == (`TCI_OFF_CTL  >> 2));
    assign wr_hit_mask = (wr_index == (`TCI_OFF_MASK >> 2));
    assign wr_hit_raw  = (wr_index == (`TCI_OFF_RAW  >> 2));
    assign wr_hit_mis  = (wr_index == (`TCI_OFF_MIS  >> 2));
    assign wr_hit_clr  = (wr_index == (`TCI_OFF_CLR  >> 2));
    // status words are read only but still answer okay
    assign wr_hit_any  = wr_hit_ctl | wr_hit_mask | wr_hit_raw | wr_hit_mis | wr_hit_clr;

    // control register; reserved bits stay zero through the write mask
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctl_r <= `TCI_CTL_RESET;
        end else if (do_write && wr_hit_ctl) begin
            ctl_r <= ctl_nxt;
        end
    end

    // mask register, one enable per source
    always @(posedge aclk) begin
        if (!aresetn) begin
            mask_r <= `TCI_IRQ_RESET;
        end else if (do_write && wr_hit_mask) begin
            mask_r <= mask_nxt;
        end
    end

    // write response; unmapped words get an error and change nothing
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TCI_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit_any ? `TCI_RESP_OKAY : `TCI_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // one-cycle clear pulse for bits written as one
    assign clr_bits = wdata_r & wbytes & `TCI_IRQ_WMASK;
    always @* begin
        clear_strobe = {`TCI_IRQ_N{1'b0}};
        if (do_write && wr_hit_clr)
            clear_strobe = clr_bits[`TCI_IRQ_N-1:0];
    end

    // capture edge detection for half a, only while it is enabled
    tci_edge_detect u_edge (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .enable      (ctl_r[`TCI_CTL_A_EN]),
        .edge_select (ctl_r[`TCI_CTL_A_EDGE_HI:`TCI_CTL_A_EDGE_LO]),
        .sample_in   (a_capture_in),
        .event_pulse (a_capture_evt)
    );

    // sources sit at the same positions in raw, masked and clear
    assign events = {b_capture_evt, b_match_evt, b_timeout_evt, 4'h0,
                     calendar_evt, a_capture_evt, a_match_evt, a_timeout_evt};

    tci_status_bits #(
        .N (`TCI_IRQ_N)
    ) u_status (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .event_in (events),
        .clear_in (clear_strobe),
        .status   (raw)
    );

    assign raw_word = {{(32-`TCI_IRQ_N){1'b0}}, raw};
    assign mis_word = raw_word & mask_r;

    // read address decode
    wire [7:0]  rd_index;
    reg  [31:0] rdata_nxt;
    reg  [1:0]  rresp_nxt;

    assign rd_index = {2'b00, s_axi_araddr[7:2]};

    // read data mux; the clear word and unmapped words read zero
    always @* begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = `TCI_RESP_OKAY;
        case (rd_index)
            (`TCI_OFF_CTL  >> 2): rdata_nxt = ctl_r;
            (`TCI_OFF_MASK >> 2): rdata_nxt = mask_r;
            (`TCI_OFF_RAW  >> 2): rdata_nxt = raw_word;
            (`TCI_OFF_MIS  >> 2): rdata_nxt = mis_word;
            (`TCI_OFF_CLR  >> 2): rdata_nxt = 32'h00000000;
            default:              rresp_nxt = `TCI_RESP_SLVERR;
        endcase
    end

    // read channel; data stands until the master takes it
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `TCI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_nxt;
            s_axi_rresp  <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // half a run level, one cycle behind its control bit
    always @(posedge aclk) begin
        if (!aresetn) begin
            half_a_run <= 1'b0;
        end else begin
            half_a_run <= ctl_r[`TCI_CTL_A_EN];
        end
    end

    // half b run level
    always @(posedge aclk) begin
        if (!aresetn) begin
            half_b_run <= 1'b0;
        end else begin
            half_b_run <= ctl_r[`TCI_CTL_B_EN];
        end
    end

    // calendar count enable
    always @(posedge aclk) begin
        if (!aresetn) begin
            calendar_count_run <= 1'b0;
        end else begin
            calendar_count_run <= ctl_r[`TCI_CTL_CAL_EN];
        end
    end

    // waveform level, registered so it cannot glitch on a control write
    always @(posedge aclk) begin
        if (!aresetn) begin
            half_a_wave_out <= 1'b0;
        end else begin
            half_a_wave_out <= a_wave_in ^ ctl_r[`TCI_CTL_A_INV];
        end
    end

    // converter trigger, gated by its enable
    always @(posedge aclk) begin
        if (!aresetn) begin
            half_a_trigger_out <= 1'b0;
        end else begin
            half_a_trigger_out <= a_trigger_in & ctl_r[`TCI_CTL_A_TRIG];
        end
    end

    // freeze follows a stall request only when permitted
    always @(posedge aclk) begin
        if (!aresetn) begin
            half_a_freeze <= 1'b0;
        end else begin
            half_a_freeze <= stall_req & ctl_r[`TCI_CTL_A_FREEZE];
        end
    end

    // level interrupt; one flop keeps the pin free of decode glitches
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |mis_word;
        end
    end

    assign half_a_edge_select = ctl_r[`TCI_CTL_A_EDGE_HI:`TCI_CTL_A_EDGE_LO];
endmodule // tci_top

// >>> tb/tb_timer_control_and_interrupt_regs.sv
// self-checking bench for the timer control and interrupt registers
`timescale 1ns/1ns
module tb_timer_control_and_interrupt_regs;
    typedef struct packed {logic [7:0] a; logic [31:0] w, e; logic [1:0] r; logic [7:0] o;} tci_row_t;
    reg         aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready, a_capture_in, a_wave_in, a_trigger_in, stall_req;
    reg  [7:0]  s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, rd_d;
    reg  [3:0]  s_axi_wstrb;
    reg  [10:0] ev;
    reg  [1:0]  rd_r, wr_r;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp, half_a_edge_select;
    wire [31:0] s_axi_rdata;
    wire        half_a_run, half_b_run, half_a_wave_out, half_a_trigger_out;
    wire        calendar_count_run, half_a_freeze, irq;
    wire        a_timeout_evt = ev[0], a_match_evt = ev[1], calendar_evt = ev[3];
    wire        b_timeout_evt = ev[8], b_match_evt = ev[9], b_capture_evt = ev[10];
    integer     miscompares, n_checks, i, k;
    // address, write, read back, response, {runs, wave, trig, cal, freeze, edge}
    tci_row_t rows [0:8] = '{
        '{8'h0C, 32'h17F, 32'h0000017F, 2'h0, 8'hDF}, '{8'h0C, 32'h0, 32'h0, 2'h0, 8'h20},
        '{8'h0C, 32'h105, 32'h105, 2'h0, 8'hE1}, '{8'h0C, 32'h72, 32'h72, 2'h0, 8'h1C},
        '{8'h18, 32'h70F, 32'h70F, 2'h0, 8'h0}, '{8'h1C, 32'h70F, 32'h0, 2'h0, 8'h0},
        '{8'h20, 32'h70F, 32'h0, 2'h0, 8'h0}, '{8'h24, 32'h0, 32'h0, 2'h0, 8'h0},
        '{8'h30, 32'hFFFFFFFF, 32'h0, 2'h2, 8'h0}};

    tci_top dut (.*);

    // free-running 50 MHz clock
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task hang;
        begin
            miscompares = miscompares + 1;
            complete_run;
        end
    endtask
    task chk(input [31:0] s, input [31:0] e, input string n);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                $display("unexpected %s expected %h seen %h", n, e, s);
                miscompares = miscompares + 1;
            end
        end
    endtask
    // each channel released at the edge that takes it; ready sampled mid-cycle
    task wr(input [7:0] a, input [31:0] d);
        integer n;
        reg ta, tw, tb;
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            tb = 1'b0;
            for (n = 0; n < 64 && !tb; n = n + 1) begin
                @(negedge aclk);
                ta = s_axi_awvalid & s_axi_awready;
                tw = s_axi_wvalid & s_axi_wready;
                tb = s_axi_bvalid;
                wr_r = s_axi_bresp;
                @(posedge aclk);
                if (ta) s_axi_awvalid <= 1'b0;
                if (tw) s_axi_wvalid <= 1'b0;
            end
            if (!tb) hang;
        end
    endtask
    task rd(input [7:0] a);
        integer n;
        reg ta, tv;
        begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            tv = 1'b0;
            for (n = 0; n < 64 && !tv; n = n + 1) begin
                @(negedge aclk);
                ta = s_axi_arvalid & s_axi_arready;
                tv = s_axi_rvalid;
                rd_d = s_axi_rdata;
                rd_r = s_axi_rresp;
                @(posedge aclk);
                if (ta) s_axi_arvalid <= 1'b0;
            end
            if (!tv) hang;
        end
    endtask
    // capture source toggles its pin, the rest pulse for one cycle
    task pulse(input integer b);
        begin
            if (b == 2) a_capture_in <= ~a_capture_in;
            else ev <= 11'h001 << b;
            @(posedge aclk);
            ev <= 11'h000;
            repeat (4) @(posedge aclk);
        end
    endtask
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, a_capture_in} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev} = 0;
        {s_axi_bready, s_axi_rready, a_wave_in, a_trigger_in, stall_req} = 5'h1F;
        {aresetn, miscompares, n_checks, s_axi_wstrb} = {1'b0, 64'h0, 4'hF};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 9; i = i + 1) begin
            wr(rows[i].a, rows[i].w);
            chk(wr_r, rows[i].r, "write response");
            @(negedge aclk);
            if (rows[i].a == 8'h0C) chk({half_a_run, half_b_run, half_a_wave_out, half_a_trigger_out,
                calendar_count_run, half_a_freeze, half_a_edge_select}, rows[i].o, "outputs");
            @(posedge aclk);
            rd(rows[i].a);
            chk(rd_d, rows[i].e, "read data");
            chk(rd_r, rows[i].r, "read response");
        end
        {a_wave_in, a_trigger_in, stall_req} <= 3'h0;
        repeat (2) @(posedge aclk);
        chk({half_a_wave_out, half_a_trigger_out, half_a_freeze}, 3'h4, "level outs");
        $display("test register table done");
        wr(8'h0C, 32'h0000000D);
        for (k = 0; k < 11; k = k + 1) if ((32'h0000070F >> k) & 1) begin
            pulse(k);
            rd(8'h1C);
            chk(rd_d, 32'h1 << k, "raw status");
            rd(8'h20);
            chk(rd_d, 32'h1 << k, "masked status");
            chk(irq, 1'b1, "irq");
            wr(8'h24, 32'h0000070F & ~(32'h1 << k));
            rd(8'h1C);
            chk(rd_d, 32'h1 << k, "raw after zero clear");
            wr(8'h24, 32'h1 << k);
            rd(8'h1C);
            chk(rd_d, 32'h0, "raw after clear");
            chk(irq, 1'b0, "irq after clear");
        end
        $display("test event sources done");
        wr(8'h18, 32'h0000070E);
        pulse(0);
        rd(8'h20);
        chk(rd_d, 32'h0, "masked status off");
        chk(irq, 1'b0, "irq masked");
        wr(8'h18, 32'h0000070F);
        rd(8'h20);
        chk(rd_d, 32'h1, "masked status on");
        // event lands on the very edge the clear takes effect
        fork
            wr(8'h24, 32'h1);
            begin
                @(posedge aclk);
                ev <= 11'h001;
                @(posedge aclk);
                ev <= 11'h000;
            end
        join
        rd(8'h1C);
        chk(rd_d, 32'h1, "event beats clear");
        // reserved edge code and a disabled half must both stay silent
        wr(8'h24, 32'h0000070F);
        wr(8'h0C, 32'h00000009);
        pulse(2);
        wr(8'h0C, 32'h0000000C);
        pulse(2);
        rd(8'h1C);
        chk(rd_d, 32'h0, "no capture event");
        $display("test mask and race done");
        wr(8'h0C, 32'h0000017F);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk({half_a_run, half_b_run, calendar_count_run, half_a_edge_select, irq}, 6'h0, "reset outs");
        @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 4; i = i + 1) begin
            rd((i == 0) ? 8'h0C : 8'h14 + 8'h04 * i[7:0]);
            chk(rd_d, 32'h0, "reset value");
        end
        // only the strobed byte lane may change
        s_axi_wstrb <= 4'h2;
        wr(8'h0C, 32'h0000017F);
        s_axi_wstrb <= 4'hF;
        rd(8'h0C);
        chk(rd_d, 32'h00000100, "byte lane write");
        $display("test mid-run reset done");
        complete_run;
    end
endmodule // tb_timer_control_and_interrupt_regs

// >>> tb/tci_monitor.sv
// concurrent checks on the timer control and interrupt register ports
`timescale 1ns/1ns
module tci_monitor (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire a_trigger_in,
    input wire stall_req,
    input wire half_a_run,
    input wire half_b_run,
    input wire half_a_trigger_out,
    input wire calendar_count_run,
    input wire half_a_freeze,
    input wire irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // trigger can only pass when the counter logic raised it
    a_trig_gated: assert property (half_a_trigger_out |-> $past(a_trigger_in))
        else $error("trigger out without trigger in");
    a_freeze_gated: assert property (half_a_freeze |-> $past(stall_req))
        else $error("freeze without stall request");
    // run levels move only after a control write completes
    a_run_on_write: assert property ($changed({half_a_run, half_b_run, calendar_count_run})
        |-> $past(s_axi_bvalid))
        else $error("run level changed without a write");
    // irq drops only by a clear or mask write
    a_irq_drop: assert property ($fell(irq) |-> $past(s_axi_bvalid))
        else $error("irq fell without a write");
    a_resp_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_write_answer: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
        else $error("write response before address and data");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule // tci_monitor

bind tci_top tci_monitor u_mon (.*);
